/* hdl/psc_pkg.sv */
// Purpose: Shared constants and carriers for the segment control word sequencer
// Assumes: 32-bit Avalon-MM register access, one 250 MHz clock
// Notes: Field positions follow the control word layout
package psc_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  // Printed offsets are word indexes, byte address is four times the index
  localparam logic [11:0] PSC_CW_BASE_IDX = 12'h804;
  localparam logic [11:0] PSC_CW_STRIDE_IDX = 12'h004;
  localparam logic [11:0] PSC_ACC_BASE_IDX = 12'h880;
  localparam logic [11:0] PSC_CTRL_IDX = 12'h8A0;
  localparam logic [11:0] PSC_STATUS_IDX = 12'h8A1;
  localparam logic [11:0] PSC_TARGET_IDX = 12'h8A2;
  localparam logic [31:0] PSC_CW_RESET = 32'h0000_0000;
  localparam logic [15:0] PSC_ACC_RESET_STEP = 16'h0064;
  localparam int PSC_NUM_SEGS = 31;
  localparam int PSC_NUM_SLOTS = 8;

  // ----------------------------------------
  // Control word fields
  // ----------------------------------------
  localparam int PSC_FA_LSB = 0;
  localparam int PSC_FB_LSB = 4;
  localparam int PSC_FC_BIT = 8;
  localparam int PSC_FD_BIT = 12;
  localparam int PSC_FE_LSB = 16;
  localparam int PSC_JUMP_LSB = 16;
  localparam int PSC_STATUS_ERR_BIT = 8;

  localparam logic [3:0] PSC_TYPE_SINGLE = 4'h0;
  localparam logic [3:0] PSC_TYPE_MULTI = 4'h1;
  localparam logic [3:0] PSC_TYPE_SPEED = 4'h2;
  localparam logic [3:0] PSC_TYPE_JUMP = 4'h3;
  localparam logic [3:0] PSC_POS_ABS = 4'h0;
  localparam logic [3:0] PSC_POS_INC = 4'h1;
  localparam logic [3:0] PSC_POS_REL = 4'h2;

  typedef enum logic [2:0] {
    PSC_IDLE,
    PSC_LOAD,
    PSC_RUN,
    PSC_SPEED_HOLD
  } psc_state_type;

  typedef struct packed {
    logic [3:0] seg_type;
    logic [3:0] pos_mode;
    logic interrupt_en;
    logic overlap_or_pps;
    logic [2:0] accel_slot;
    logic [4:0] jump_target;
  } psc_fields_type;

  // Outgoing plan handed to the trajectory planner
  typedef struct packed {
    logic start;
    logic speed_mode;
    logic pulses_per_second_unit;
    logic blend_from_speed;
    logic zero_delay;
    logic carry_remainder;
    logic [31:0] target_position;
    logic [31:0] speed_value;
    logic [15:0] accel_time;
  } psc_plan_type;

endpackage

/* hdl/psc_segment_ctrl.sv */
// Purpose: Segment control word store and internal_segment_program sequencer
// Assumes: Planner reports decel point and completion as pulses
// Notes: Only the acceleration-time selector and the jump target of the upper half are decoded
`timescale 1ns/10ps
module psc_segment_ctrl
  import psc_pkg::*;
#(
  parameter int NUM_SEGS = PSC_NUM_SEGS,
  parameter int NUM_SLOTS = PSC_NUM_SLOTS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Avalon-MM slave
  input wire logic [13:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Segment selection and trigger
  input wire logic [4:0] segment_select_i,
  input wire logic segment_trigger_input_i,
  input wire logic stop_i,
  // Planner feedback
  input wire logic [31:0] measured_position_i,
  input wire logic [31:0] segment_value_i,
  input wire logic planner_done_i,
  input wire logic planner_decel_i,
  input wire logic speed_reached_i,
  // Plan to planner
  output psc_plan_type plan_o,
  output logic [4:0] segment_value_index_o,
  output logic busy_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [NUM_SEGS-1:0][31:0] cw;
    logic [NUM_SLOTS-1:0][15:0] acc;
    logic enable;
    psc_state_type state;
    logic [4:0] cur_seg;
    logic trig_d;
    logic err;
    logic [31:0] prev_cmd;
    psc_fields_type cur;
    psc_plan_type plan;
    logic ack;
    logic [31:0] rdata;
  } psc_regs_type;

  psc_regs_type s_reg;
  psc_regs_type s_next;

  // Shared decode of a control word
  function automatic psc_fields_type decode_cw(input logic [31:0] w);
    psc_fields_type f;
    f.seg_type = w[PSC_FA_LSB +: 4];
    f.pos_mode = w[PSC_FB_LSB +: 4];
    f.interrupt_en = w[PSC_FC_BIT];
    f.overlap_or_pps = w[PSC_FD_BIT];
    f.accel_slot = w[PSC_FE_LSB +: 3];
    f.jump_target = w[PSC_JUMP_LSB +: 5];
    return f;
  endfunction

  // Valid codes for a given word
  function automatic logic fields_ok(input psc_fields_type f);
    logic ok;
    ok = 1'b0;
    case (f.seg_type)
      PSC_TYPE_SINGLE, PSC_TYPE_MULTI: begin
        ok = (f.pos_mode <= PSC_POS_REL);
      end
      PSC_TYPE_SPEED: begin
        ok = (f.pos_mode <= PSC_POS_INC);
      end
      PSC_TYPE_JUMP: begin
        ok = (f.jump_target != 5'h00);
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction

  // Segment numbers run 1..31; index is number minus one
  function automatic logic [4:0] seg_index(input logic [4:0] n);
    return n - 5'd1;
  endfunction

  logic [11:0] idx;
  logic acc_hit;
  logic cw_hit;
  logic [11:0] cw_off;
  logic [4:0] cw_sel;
  logic trig_edge;
  logic [4:0] next_seg;
  psc_fields_type nf;
  logic [31:0] wmask;

  assign idx = avs_address_i[13:2];
  assign cw_off = idx - PSC_CW_BASE_IDX;
  assign cw_sel = 5'(cw_off >> 2);
  assign cw_hit = (idx >= PSC_CW_BASE_IDX) && (cw_off[1:0] == 2'b00) && (cw_off[11:2] < 10'(NUM_SEGS));
  assign acc_hit = (idx >= PSC_ACC_BASE_IDX) && (idx < PSC_ACC_BASE_IDX + 12'(NUM_SLOTS));
  assign trig_edge = segment_trigger_input_i && !s_reg.trig_d;
  assign next_seg = (s_reg.cur_seg == 5'(NUM_SEGS)) ? 5'd1 : s_reg.cur_seg + 5'd1;

  always_comb begin
    s_next = s_reg;
    s_next.trig_d = segment_trigger_input_i;
    s_next.ack = 1'b0;
    s_next.plan.start = 1'b0;
    nf = '0;
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{avs_byteenable_i[b]}};
    end

    // ----------------------------------------
    // Register access
    // ----------------------------------------
    // One wait cycle keeps read data registered
    if ((avs_read_i || avs_write_i) && !s_reg.ack) begin
      s_next.ack = 1'b1;
      s_next.rdata = 32'h0000_0000;
      if (cw_hit) begin
        s_next.rdata = s_reg.cw[cw_sel];
      end else if (acc_hit) begin
        s_next.rdata = {16'h0000, s_reg.acc[3'(idx - PSC_ACC_BASE_IDX)]};
      end else if (idx == PSC_CTRL_IDX) begin
        s_next.rdata = {31'h0, s_reg.enable};
      end else if (idx == PSC_STATUS_IDX) begin
        s_next.rdata = {23'h0, s_reg.err, (s_reg.state != PSC_IDLE), 2'b00, s_reg.cur_seg};
      end else if (idx == PSC_TARGET_IDX) begin
        s_next.rdata = s_reg.prev_cmd;
      end
    end
    // Writes land only on the edge that completes the access
    if (avs_write_i && s_reg.ack) begin
      if (cw_hit) begin
        s_next.cw[cw_sel] = (s_reg.cw[cw_sel] & ~wmask) | (avs_writedata_i & wmask);
      end else if (acc_hit) begin
        s_next.acc[3'(idx - PSC_ACC_BASE_IDX)] = avs_writedata_i[15:0];
      end else if (idx == PSC_CTRL_IDX) begin
        if (avs_byteenable_i[0]) begin
          s_next.enable = avs_writedata_i[0];
        end
      end else if (idx == PSC_STATUS_IDX) begin
        if (avs_writedata_i[PSC_STATUS_ERR_BIT]) begin
          s_next.err = 1'b0;
        end
      end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    case (s_reg.state)
      PSC_IDLE: begin
        if (trig_edge && s_reg.enable && segment_select_i != 5'd0) begin
          s_next.cur_seg = segment_select_i;
          s_next.state = PSC_LOAD;
        end
      end
      PSC_LOAD: begin
        nf = decode_cw(s_reg.cw[seg_index(s_reg.cur_seg)]);
        s_next.cur = nf;
        if (!fields_ok(nf)) begin
          s_next.err = 1'b1;
          s_next.state = PSC_IDLE;
        end else if (nf.seg_type == PSC_TYPE_JUMP) begin
          s_next.cur_seg = nf.jump_target;
          s_next.state = PSC_LOAD;
        end else begin
          s_next.plan.start = 1'b1;
          s_next.plan.accel_time = s_reg.acc[nf.accel_slot];
          s_next.plan.speed_mode = (nf.seg_type == PSC_TYPE_SPEED);
          s_next.plan.pulses_per_second_unit = (nf.seg_type == PSC_TYPE_SPEED) && nf.overlap_or_pps;
          s_next.plan.blend_from_speed = (nf.seg_type == PSC_TYPE_MULTI) && nf.overlap_or_pps;
          s_next.plan.zero_delay = (nf.seg_type == PSC_TYPE_MULTI) && nf.overlap_or_pps;
          s_next.plan.carry_remainder = (s_reg.state == PSC_LOAD) && s_reg.cur.interrupt_en;
          s_next.plan.speed_value = segment_value_i;
          if (nf.seg_type == PSC_TYPE_SPEED) begin
            s_next.plan.target_position = s_reg.plan.target_position;
            s_next.state = PSC_SPEED_HOLD;
          end else begin
            case (nf.pos_mode)
              PSC_POS_ABS: s_next.plan.target_position = segment_value_i;
              PSC_POS_REL: s_next.plan.target_position = measured_position_i + segment_value_i;
              default: s_next.plan.target_position = s_reg.prev_cmd + segment_value_i;
            endcase
            s_next.prev_cmd = s_next.plan.target_position;
            s_next.state = PSC_RUN;
          end
        end
      end
      PSC_RUN: begin
        if (trig_edge && segment_select_i != 5'd0 && s_reg.cur.interrupt_en) begin
          s_next.cur_seg = segment_select_i;
          s_next.state = PSC_LOAD;
        end else if (s_reg.cur.seg_type == PSC_TYPE_MULTI && s_reg.cur.overlap_or_pps && planner_decel_i) begin
          s_next.cur_seg = next_seg;
          s_next.state = PSC_LOAD;
        end else if (planner_done_i) begin
          if (s_reg.cur.seg_type == PSC_TYPE_MULTI) begin
            s_next.cur_seg = next_seg;
            s_next.state = PSC_LOAD;
          end else begin
            s_next.state = PSC_IDLE;
          end
        end
      end
      PSC_SPEED_HOLD: begin
        if (trig_edge && segment_select_i != 5'd0) begin
          s_next.cur_seg = segment_select_i;
          s_next.state = PSC_LOAD;
        end else if (speed_reached_i && s_reg.cur.pos_mode == PSC_POS_INC) begin
          s_next.cur_seg = next_seg;
          s_next.state = PSC_LOAD;
        end
      end
      default: begin
        s_next.state = PSC_IDLE;
      end
    endcase

    if (stop_i) begin
      s_next.state = PSC_IDLE;
    end
    if (s_reg.plan.start && s_next.plan.start) begin
      s_next.plan.start = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_reg <= '0;
      for (int i = 0; i < NUM_SEGS; i++) begin
        s_reg.cw[i] <= PSC_CW_RESET;
      end
      for (int j = 0; j < NUM_SLOTS; j++) begin
        s_reg.acc[j] <= 16'((j + 1) * PSC_ACC_RESET_STEP);
      end
      s_reg.state <= PSC_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !s_reg.ack;
  assign avs_readdata_o = s_reg.rdata;
  assign plan_o = s_reg.plan;
  assign segment_value_index_o = seg_index(s_reg.cur_seg);
  assign busy_o = (s_reg.state != PSC_IDLE);

endmodule

/* verification/psc_planner_model.sv */
// Purpose: Behavioural trajectory planner facing the segment sequencer
// Assumes: Planner runs latency_i plus three cycles per segment
// Notes: Segment value is 256 times the segment number
`timescale 1ns/10ps
module psc_planner_model
  import psc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // From sequencer
  input wire psc_plan_type plan_i,
  input wire logic [4:0] index_i,
  input wire logic [7:0] latency_i,
  // To sequencer
  output logic done_o,
  output logic decel_o,
  output logic speed_reached_o,
  output logic [31:0] segment_value_o,
  output logic [31:0] measured_position_o
);
  logic [7:0] cnt_reg;
  logic spd_reg;
  assign segment_value_o = {19'h00000, index_i + 5'h01, 8'h00};
  assign measured_position_o = 32'h0000_5000;
  // Decel point always ahead of the end, so overlap can be seen
  assign decel_o = (cnt_reg == 8'h03) && !spd_reg;
  assign done_o = (cnt_reg == 8'h01) && !spd_reg;
  // One-cycle pulse, so a stale level cannot advance the next speed segment
  assign speed_reached_o = spd_reg && (cnt_reg == 8'h01);
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= 8'h00;
      spd_reg <= 1'h0;
    end else if (plan_i.start) begin
      cnt_reg <= latency_i + 8'h03;
      spd_reg <= plan_i.speed_mode;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end
endmodule

/* verification/psc_segment_ctrl_asserts.sv */
// Purpose: Port-level checks of the segment sequencer
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to every sequencer instance
`timescale 1ns/10ps
module psc_segment_ctrl_asserts
  import psc_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire psc_plan_type plan_o,
  input wire logic [4:0] segment_value_index_o,
  input wire logic busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_load;
    $rose(busy_o);
  endsequence
  property p_one_wait;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  property p_no_req;
    !(avs_read_i || avs_write_i) |-> !avs_waitrequest_o;
  endproperty
  property p_start_pulse;
    plan_o.start |=> !plan_o.start;
  endproperty
  property p_start_busy;
    plan_o.start |-> busy_o;
  endproperty
  property p_index;
    busy_o |-> segment_value_index_o <= 5'h1E;
  endproperty
  property p_overlap;
    plan_o.blend_from_speed |-> plan_o.zero_delay && !plan_o.speed_mode;
  endproperty
  property p_unit;
    plan_o.pulses_per_second_unit |-> plan_o.speed_mode;
  endproperty
  // Jump chains add a cycle per hop, hence the wide window
  property p_load;
    s_load |-> ##[1:32] (plan_o.start || !busy_o);
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("waitrequest longer than one cycle");
  a_no_req: assert property (p_no_req) else $error("waitrequest without request");
  a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
  a_start_busy: assert property (p_start_busy) else $error("start while idle");
  a_index: assert property (p_index) else $error("segment index out of range");
  a_overlap: assert property (p_overlap) else $error("overlap without zero delay");
  a_unit: assert property (p_unit) else $error("pps unit outside speed segment");
  a_load: assert property (p_load) else $error("load led to no start");
endmodule
bind psc_segment_ctrl psc_segment_ctrl_asserts u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o), .plan_o(plan_o),
  .segment_value_index_o(segment_value_index_o), .busy_o(busy_o));

/* verification/test_psc_segment_ctrl.sv */
// Purpose: Register-driven scenarios for the segment sequencer
// Assumes: One wait cycle per access, planner model on the far side
// Notes: Segment n value is n times 256, measured position 0x5000
`timescale 1ns/10ps
module test_psc_segment_ctrl
  import psc_pkg::*;
;
  logic clk_i = 1'h0;
  logic nrst_i = 1'h0;
  logic [13:0] adr = 14'h0000;
  logic rd = 1'h0, wr = 1'h0, trg = 1'h0, stp = 1'h0, wt, dn, dec, spd, busy, ok;
  logic [31:0] wd = 32'h0, rdat, sval, meas, q, n;
  logic [4:0] sel = 5'h00, vidx;
  logic [7:0] lat = 8'h02;
  psc_plan_type plan;
  logic [31:0] cw [8] = '{32'h0003_0000, 32'h0000_1011, 32'h0000_0020, 32'h0001_0003, 32'h0000_0004,
    32'h0000_1002, 32'h0000_0012, 32'h0000_0000};
  int n_fail = 0;
  int compares = 0;
  psc_segment_ctrl uut (.clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .segment_select_i(sel), .segment_trigger_input_i(trg), .stop_i(stp),
    .measured_position_i(meas), .segment_value_i(sval), .planner_done_i(dn), .planner_decel_i(dec),
    .speed_reached_i(spd), .plan_o(plan), .segment_value_index_o(vidx), .busy_o(busy));
  psc_planner_model u_plan (.clk_i(clk_i), .nrst_i(nrst_i), .plan_i(plan), .index_i(vidx), .latency_i(lat),
    .done_o(dn), .decel_o(dec), .speed_reached_o(spd), .segment_value_o(sval), .measured_position_o(meas));
  initial begin
    forever #2 clk_i = !clk_i;
  end
  task automatic summarize;
    if (n_fail == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Decision taken mid-cycle equals what the rising edge samples
  task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] d, output logic [31:0] r);
    logic done;
    done = 1'h0;
    adr <= {idx, 2'h0};
    wr <= w;
    rd <= !w;
    wd <= d;
    for (int i = 0; i < 20 && !done; i++) begin
      @(negedge clk_i);
      done = (wt === 1'h0);
      r = rdat;
      @(posedge clk_i);
    end
    rd <= 1'h0;
    wr <= 1'h0;
    if (!done) begin
      n_fail++;
      summarize();
    end
    @(posedge clk_i);
  endtask
  task automatic trig(input logic [4:0] s);
    @(posedge clk_i);
    sel <= s;
    @(posedge clk_i);
    trg <= 1'h1;
    @(posedge clk_i);
    trg <= 1'h0;
  endtask
  task automatic wstart(output logic f);
    f = 1'h0;
    for (int i = 0; i < 40 && !f; i++) begin
      @(negedge clk_i);
      f = (plan.start === 1'h1);
    end
    if (!f) n_fail++;
  endtask
  // Counts starts over a quiet spell, then reports idle
  task automatic quiet(output logic [31:0] c, output logic idle);
    c = 32'h0;
    for (int i = 0; i < 30; i++) begin
      @(negedge clk_i);
      if (plan.start !== 1'h0) c++;
    end
    idle = (busy === 1'h0);
    @(posedge clk_i);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'h1;
    @(posedge clk_i);
    bus(1'h0, PSC_CW_BASE_IDX, 32'h0, q);
    chk(q, PSC_CW_RESET, "cw reset");
    for (int k = 0; k < 8; k++) begin
      bus(1'h0, PSC_ACC_BASE_IDX + 12'(k), 32'h0, q);
      chk(q, 32'(PSC_ACC_RESET_STEP) * 32'(k + 1), "accel slot");
    end
    bus(1'h0, 12'h7FF, 32'h0, q);
    chk(q, 32'h0, "unmapped");
    bus(1'h1, PSC_CTRL_IDX, 32'h1, q);
    for (int k = 0; k < 8; k++) begin
      bus(1'h1, PSC_CW_BASE_IDX + 12'(PSC_CW_STRIDE_IDX * k), cw[k], q);
      bus(1'h0, PSC_CW_BASE_IDX + 12'(PSC_CW_STRIDE_IDX * k), 32'h0, q);
      chk(q, cw[k], "cw readback");
    end
    trig(5'h01);
    wstart(ok);
    chk(ok, 1'h1, "single start");
    chk(plan.target_position, 32'h100, "abs target");
    chk(plan.accel_time, 16'h0190, "accel time");
    quiet(n, ok);
    chk({n[30:0], ok}, 32'h1, "single end");
    lat <= 8'h0C;
    trig(5'h02);
    wstart(ok);
    chk(plan.target_position, 32'h300, "inc target");
    chk({plan.blend_from_speed, plan.zero_delay}, 2'h3, "overlap flags");
    wstart(ok);
    chk(ok, 1'h1, "multi chain");
    chk(plan.target_position, 32'h5300, "rel target");
    quiet(n, ok);
    trig(5'h04);
    wstart(ok);
    chk({plan.target_position, vidx}, {32'h100, 5'h00}, "jump target");
    quiet(n, ok);
    trig(5'h05);
    quiet(n, ok);
    chk({n[30:0], ok}, 32'h1, "bad code no start");
    bus(1'h0, PSC_STATUS_IDX, 32'h0, q);
    chk(q[PSC_STATUS_ERR_BIT], 1'h1, "error flag");
    trig(5'h06);
    wstart(ok);
    chk({plan.speed_mode, plan.pulses_per_second_unit}, 2'h3, "speed pps");
    quiet(n, ok);
    chk({n[30:0], ok}, 32'h0, "speed hold");
    trig(5'h07);
    wstart(ok);
    chk(plan.speed_mode, 1'h1, "speed auto start");
    wstart(ok);
    chk({ok, plan.target_position}, {1'h1, 32'h800}, "speed auto advance");
    stp <= 1'h1;
    @(posedge clk_i);
    stp <= 1'h0;
    @(negedge clk_i);
    chk(busy, 1'h0, "stop idle");
    summarize();
  end
endmodule
